// ### include/scs_pkg.sv
// Purpose: constants and types shared by the scan cycle sequencer
// Assumes: 50 MHz reference clock
// Notes:   times are kept in their own unit, cycle counts derive from them
`default_nettype none
package scs_pkg;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned MS_CYC        = 1000 * CLK_MHZ;
  localparam int unsigned WDOG_MS       = 100;
  localparam int unsigned WDOG_CYC      = WDOG_MS * MS_CYC;
  localparam int unsigned OVH_US        = 300;
  localparam int unsigned OVH_CYC       = OVH_US * CLK_MHZ;
  localparam int unsigned HOSTA_CHAN_MS = 2;
  localparam int unsigned HOSTA_MIN_MS  = 2;
  localparam int unsigned HOSTB_BASE_MS = 5;
  localparam int unsigned HOSTB_CHAN_MS = 1;
  localparam int unsigned PROG_START    = 0;
  localparam int unsigned N_IO          = 8;
  localparam int unsigned PROG_DEPTH    = 16;

  // instruction opcodes: load, load inverted, and, store to output image
  localparam logic [1:0] OP_LD  = 2'h0;
  localparam logic [1:0] OP_LDN = 2'h1;
  localparam logic [1:0] OP_AND = 2'h2;
  localparam logic [1:0] OP_OUT = 2'h3;

  // gray along init -> common -> exec -> refresh -> bus -> console
  typedef enum logic [3:0] {
    ST_COPY    = 4'h0,
    ST_CLEAR   = 4'h1,
    ST_CHECK   = 4'h3,
    ST_COMMON  = 4'h2,
    ST_EXEC    = 4'h6,
    ST_REFRESH = 4'h7,
    ST_BUS     = 4'h5,
    ST_CONSOLE = 4'h4,
    ST_HALT    = 4'hC
  } scs_state_t;

  typedef struct packed {
    logic       host_b;
    logic [3:0] chan_count;
    logic [7:0] filter_val;
  } scs_cfg_t;
endpackage
`default_nettype wire

// ### hdl/scs_sequencer.sv
// Purpose: scan cycle sequencer of a small programmable controller
// Assumes: i_nv_data answers o_nv_addr in the same cycle; inputs synchronous
// Notes:   filter value counts reference clock cycles
`default_nettype none
// What this block does
// - power-up: copy program, clear state, check bus
// - then loop common, execute, refresh, bus, console
// - execute instructions from address 000 to end
// - refresh I/O in batch, only after execution
// - output image into buffer, buffer drives outputs
// - sample inputs into buffer, program reads buffer
// - bus phase exchanges data with remote bus
// - final phase grants console access
// - watchdog restarted in common processing
// - cycle over 100 ms halts the CPU
// - non-program phases total about 300 us
// - input before refresh reaches outputs next cycle
// - input after refresh waits one more cycle
// - inputs pass noise filter of set value
// - first host type: 2 ms per channel, min 2
// - second host type: 5 ms plus 1 ms/channel
module scs_sequencer #(
  parameter int unsigned N     = scs_pkg::N_IO,
  parameter int unsigned DEPTH = scs_pkg::PROG_DEPTH,
  parameter int unsigned P_MS_CYC   = scs_pkg::MS_CYC,
  parameter int unsigned P_WDOG_CYC = scs_pkg::WDOG_CYC,
  parameter int unsigned P_OVH_CYC  = scs_pkg::OVH_CYC,
  localparam int unsigned AW = $clog2(2 * N),
  localparam int unsigned PW = $clog2(DEPTH),
  localparam int unsigned IW = 2 + AW
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire scs_pkg::scs_cfg_t i_cfg,
  input  wire logic [PW-1:0]    i_end_addr,
  input  wire logic [IW-1:0]    i_nv_data,
  input  wire logic             i_bus_ok,
  input  wire logic [N-1:0]     i_inputs,
  input  wire logic [N-1:0]     i_bus_in,
  input  wire logic             i_err_clear,
  output logic [PW-1:0]         o_nv_addr,
  output logic [PW-1:0]         o_exec_addr,
  output logic [N-1:0]          o_outputs,
  output logic [N-1:0]          o_bus_out,
  output logic                  o_bus_busy,
  output logic                  o_console_grant,
  output logic                  o_wdog_err,
  output logic                  o_init_err,
  output scs_pkg::scs_state_t   o_phase
);
  typedef struct packed {
    scs_pkg::scs_state_t     st;
    logic [DEPTH-1:0][IW-1:0] mem;
    logic [PW-1:0]           nv_addr;
    logic [PW-1:0]           pc;
    logic                    acc;
    logic [N-1:0]            out_img;
    logic [N-1:0]            out_buf;
    logic [N-1:0]            in_buf;
    logic [N-1:0]            bus_in_buf;
    logic [N-1:0]            bus_out;
    logic [N-1:0]            filt;
    logic [N-1:0][7:0]       filt_cnt;
    logic [31:0]             wdog;
    logic [31:0]             ovh;
    logic [31:0]             bus_cnt;
    logic                    bus_busy;
    logic                    grant;
    logic                    wdog_err;
    logic                    init_err;
  } scs_regs_t;

  scs_regs_t s_r;
  scs_regs_t s_nxt;

  function automatic logic [31:0] xfer_cycles(input scs_pkg::scs_cfg_t cfg);
    int unsigned ms;
    if (cfg.host_b) begin
      ms = scs_pkg::HOSTB_BASE_MS + scs_pkg::HOSTB_CHAN_MS * cfg.chan_count;
    end else begin
      ms = scs_pkg::HOSTA_CHAN_MS * cfg.chan_count;
      if (ms < scs_pkg::HOSTA_MIN_MS) begin
        ms = scs_pkg::HOSTA_MIN_MS;
      end
    end
    return 32'(ms * P_MS_CYC);
  endfunction

  logic [IW-1:0]    instr;
  logic [2*N-1:0]   src_bits;
  logic             running;

  assign instr    = s_r.mem[s_r.pc];
  assign src_bits = {s_r.bus_in_buf, s_r.in_buf};
  assign running  = !(s_r.st inside {scs_pkg::ST_COPY, scs_pkg::ST_CLEAR,
                                      scs_pkg::ST_CHECK, scs_pkg::ST_HALT});

  always_comb begin
    s_nxt      = s_r;
    s_nxt.wdog = s_r.wdog + 32'h1;
    if (s_r.st != scs_pkg::ST_EXEC) begin
      s_nxt.ovh = s_r.ovh + 32'h1;
    end
    // noise filter: a level must hold filter_val cycles before it is taken
    for (int i = 0; i < N; i++) begin
      if (i_inputs[i] == s_r.filt[i]) begin
        s_nxt.filt_cnt[i] = 8'h0;
      end else if (s_r.filt_cnt[i] >= i_cfg.filter_val) begin
        s_nxt.filt[i]     = i_inputs[i];
        s_nxt.filt_cnt[i] = 8'h0;
      end else begin
        s_nxt.filt_cnt[i] = s_r.filt_cnt[i] + 8'h1;
      end
    end
    // the remote transfer runs behind the scan so it does not stretch overhead
    if (s_r.bus_busy) begin
      s_nxt.bus_cnt = s_r.bus_cnt - 32'h1;
      if (s_r.bus_cnt <= 32'h1) begin
        s_nxt.bus_busy = 1'b0;
      end
    end
    case (s_r.st)
      scs_pkg::ST_COPY: begin
        s_nxt.mem[s_r.nv_addr] = i_nv_data;
        s_nxt.nv_addr          = s_r.nv_addr + PW'(1);
        if (s_r.nv_addr == PW'(DEPTH - 1)) begin
          s_nxt.st = scs_pkg::ST_CLEAR;
        end
      end
      scs_pkg::ST_CLEAR: begin
        s_nxt.acc        = 1'b0;
        s_nxt.out_img    = '0;
        s_nxt.out_buf    = '0;
        s_nxt.in_buf     = '0;
        s_nxt.bus_in_buf = '0;
        s_nxt.bus_out    = '0;
        s_nxt.filt       = '0;
        s_nxt.filt_cnt   = '0;
        s_nxt.bus_busy   = 1'b0;
        s_nxt.bus_cnt    = 32'h0;
        s_nxt.st         = scs_pkg::ST_CHECK;
      end
      scs_pkg::ST_CHECK: begin
        if (i_bus_ok) begin
          s_nxt.st = scs_pkg::ST_COMMON;
        end else begin
          s_nxt.init_err = 1'b1;
          s_nxt.st       = scs_pkg::ST_HALT;
        end
      end
      scs_pkg::ST_COMMON: begin
        s_nxt.wdog = 32'h0;
        s_nxt.ovh  = 32'h1;
        s_nxt.pc   = PW'(scs_pkg::PROG_START);
        s_nxt.st   = scs_pkg::ST_EXEC;
      end
      scs_pkg::ST_EXEC: begin
        case (instr[IW-1:AW])
          scs_pkg::OP_LD:  s_nxt.acc = src_bits[instr[AW-1:0]];
          scs_pkg::OP_LDN: s_nxt.acc = !src_bits[instr[AW-1:0]];
          scs_pkg::OP_AND: s_nxt.acc = s_r.acc & src_bits[instr[AW-1:0]];
          scs_pkg::OP_OUT: s_nxt.out_img[instr[AW-2:0]] = s_r.acc;
          default:         s_nxt.acc = s_r.acc;
        endcase
        if (s_r.pc == i_end_addr) begin
          s_nxt.st = scs_pkg::ST_REFRESH;
        end else begin
          s_nxt.pc = s_r.pc + PW'(1);
        end
      end
      scs_pkg::ST_REFRESH: begin
        // both buffers move in one cycle, so an input taken here shows
        // at the outputs one whole cycle later
        s_nxt.out_buf = s_r.out_img;
        s_nxt.in_buf  = s_r.filt;
        s_nxt.st      = scs_pkg::ST_BUS;
      end
      scs_pkg::ST_BUS: begin
        if (!s_r.bus_busy) begin
          s_nxt.bus_out    = s_r.out_buf;
          s_nxt.bus_in_buf = i_bus_in;
          s_nxt.bus_cnt    = xfer_cycles(i_cfg);
          s_nxt.bus_busy   = 1'b1;
        end
        s_nxt.st = scs_pkg::ST_CONSOLE;
      end
      scs_pkg::ST_CONSOLE: begin
        // console keeps the slot until the fixed overhead is used up
        if (s_r.ovh >= 32'(P_OVH_CYC - 1)) begin
          s_nxt.st = scs_pkg::ST_COMMON;
        end
      end
      scs_pkg::ST_HALT: begin
        if (i_err_clear) begin
          s_nxt.st       = scs_pkg::ST_COPY;
          s_nxt.nv_addr  = '0;
          s_nxt.wdog_err = 1'b0;
          s_nxt.init_err = 1'b0;
        end
      end
      default: s_nxt.st = scs_pkg::ST_HALT;
    endcase
    if (running && s_r.wdog >= 32'(P_WDOG_CYC)) begin
      s_nxt.st       = scs_pkg::ST_HALT;
      s_nxt.wdog_err = 1'b1;
    end
    s_nxt.grant = (s_nxt.st == scs_pkg::ST_CONSOLE);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s_r    <= '0;
      s_r.st <= scs_pkg::ST_COPY;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_nv_addr       = s_r.nv_addr;
  assign o_exec_addr     = s_r.pc;
  assign o_outputs       = s_r.out_buf;
  assign o_bus_out       = s_r.bus_out;
  assign o_bus_busy      = s_r.bus_busy;
  assign o_console_grant = s_r.grant;
  assign o_wdog_err      = s_r.wdog_err;
  assign o_init_err      = s_r.init_err;
  assign o_phase         = s_r.st;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence tail_s;
    s_r.st == scs_pkg::ST_REFRESH ##1 s_r.st == scs_pkg::ST_BUS
      ##1 s_r.st == scs_pkg::ST_CONSOLE;
  endsequence

  init_bus_check_a: assert property (
    s_r.st == scs_pkg::ST_CHECK && !i_bus_ok |=> s_r.st == scs_pkg::ST_HALT && o_init_err)
    else $error("bus check failure did not halt");
  cycle_order_a: assert property (
    s_r.st == scs_pkg::ST_EXEC && s_r.pc == i_end_addr && s_r.wdog < 32'(P_WDOG_CYC - 4)
      |=> tail_s)
    else $error("phase order broken after execution");
  exec_start_a: assert property (
    s_r.st == scs_pkg::ST_COMMON |=> s_r.st == scs_pkg::ST_EXEC && s_r.pc == '0
      && s_r.wdog == 32'h0)
    else $error("execution did not start at address zero");
  no_mid_refresh_a: assert property (
    s_r.st inside {scs_pkg::ST_COMMON, scs_pkg::ST_EXEC} |=> $stable(o_outputs))
    else $error("outputs moved during execution");
  out_refresh_a: assert property (
    s_r.st == scs_pkg::ST_REFRESH |=> o_outputs == $past(s_r.out_img))
    else $error("outputs not taken from output image");
  in_refresh_a: assert property (
    s_r.st == scs_pkg::ST_REFRESH |=> s_r.in_buf == $past(s_r.filt)
      ##1 $stable(s_r.in_buf))
    else $error("input buffer not sampled at refresh");
  bus_launch_a: assert property (
    s_r.st == scs_pkg::ST_BUS && !o_bus_busy && !$past(o_bus_busy)
      |=> o_bus_busy && o_bus_out == $past(s_r.out_buf))
    else $error("bus exchange not launched");
  console_grant_a: assert property (
    o_console_grant == (s_r.st == scs_pkg::ST_CONSOLE))
    else $error("console grant outside console phase");
  wdog_halt_a: assert property (
    running && s_r.wdog >= 32'(P_WDOG_CYC) |=> s_r.st == scs_pkg::ST_HALT && o_wdog_err)
    else $error("watchdog did not halt");
  halt_hold_a: assert property (
    s_r.st == scs_pkg::ST_HALT && !i_err_clear
      |=> s_r.st == scs_pkg::ST_HALT && $stable(o_wdog_err) && !o_console_grant)
    else $error("halt left without clear");
  xfer_time_a: assert property (
    s_r.st == scs_pkg::ST_BUS && !s_r.bus_busy && !i_cfg.host_b && i_cfg.chan_count < 4'h2
      |=> s_r.bus_cnt == 32'(scs_pkg::HOSTA_MIN_MS * P_MS_CYC))
    else $error("first host transfer below minimum");
endmodule
`default_nettype wire

// ### dv/scs_bus_master.sv
// Purpose: remote bus master model at the sequencer's far side
// Assumes: one clock shared with the sequencer
// Notes:   input word changes after each finished transfer
`default_nettype none
module scs_bus_master (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_link_up,
  input  wire logic       i_bus_busy,
  input  wire logic [7:0] i_bus_out,
  output logic            o_bus_ok,
  output logic [7:0]      o_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_r;
  logic [7:0] seen_r;
  assign o_bus_ok = i_link_up;
  always_ff @(posedge i_ref_clk) begin
    busy_r <= i_bus_busy;
    if (i_reset) begin
      o_bus_in <= 8'h5A;
    end else if (busy_r && !i_bus_busy) begin
      // a new word per exchange, so a stale capture is visible
      o_bus_in <= 8'($urandom);
      seen_r   <= i_bus_out;
    end
  end
endmodule
`default_nettype wire

// ### dv/scs_sequencer_tb_top.sv
// Purpose: self-checking bench of the scan cycle sequencer
// Assumes: short sim counts for ms, watchdog and overhead
// Notes:   program reads only local inputs; outputs lag one scan
`default_nettype none
module scs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  localparam int WD = 30;
  localparam int OV = 20;
  logic              i_ref_clk, i_reset, i_err_clear, link_up, bus_ok, busy, grant;
  logic              wdog_err, init_err;
  scs_pkg::scs_cfg_t cfg;
  logic [3:0]        end_addr, nv_addr, exec_addr;
  logic [7:0]        ins, outs, bus_in, bus_out, v0, v1;
  logic [5:0]        nv_data;
  logic [5:0]        prog [16];
  scs_pkg::scs_state_t phase;
  int                failures, n_checks, n;
  assign nv_data = prog[nv_addr];
  scs_sequencer #(.P_MS_CYC(MS), .P_WDOG_CYC(WD), .P_OVH_CYC(OV)) scs_sequencer_i (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cfg(cfg), .i_end_addr(end_addr),
    .i_nv_data(nv_data), .i_bus_ok(bus_ok), .i_inputs(ins), .i_bus_in(bus_in),
    .i_err_clear(i_err_clear), .o_nv_addr(nv_addr), .o_exec_addr(exec_addr),
    .o_outputs(outs), .o_bus_out(bus_out), .o_bus_busy(busy), .o_console_grant(grant),
    .o_wdog_err(wdog_err), .o_init_err(init_err), .o_phase(phase));
  scs_bus_master scs_bus_master_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_link_up(link_up), .i_bus_busy(busy), .i_bus_out(bus_out), .o_bus_ok(bus_ok),
    .o_bus_in(bus_in));
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [7:0] f_out(input logic [7:0] v);
    return {5'h00, v[0] & v[2], ~v[1], v[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_ph(input scs_pkg::scs_state_t p);
    n = 0;
    while (phase !== p && n < 300) begin
      @(negedge i_ref_clk);
      n++;
    end
  endtask
  // one scan from COMMON to the next COMMON; new inputs land early in EXEC
  task automatic scan(input logic [7:0] nin);
    logic [7:0] o0;
    int c;
    chk(phase, scs_pkg::ST_COMMON);
    o0 = outs;
    c = 1;
    for (int k = 0; k <= 6; k++) begin
      @(posedge i_ref_clk);
      if (k == 0) ins <= nin;
      @(negedge i_ref_clk);
      c++;
      chk(phase, scs_pkg::ST_EXEC);
      chk(exec_addr, k);
      chk(outs, o0);
    end
    @(negedge i_ref_clk);
    chk(phase, scs_pkg::ST_REFRESH);
    @(negedge i_ref_clk);
    chk(phase, scs_pkg::ST_BUS);
    c += 2;
    while (phase !== scs_pkg::ST_COMMON && c < 100) begin
      @(negedge i_ref_clk);
      c++;
      chk(grant, phase == scs_pkg::ST_CONSOLE);
    end
    chk(c - 1, OV + 7);
  endtask
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(99));
    foreach (prog[i]) prog[i] = 6'h00;
    {prog[1], prog[2], prog[3], prog[5], prog[6]} = {6'h30, 6'h11, 6'h31, 6'h22, 6'h32};
    i_reset = 1'b1; i_err_clear = 1'b0; link_up = 1'b1; cfg = '0; end_addr = 4'h6;
    ins = 8'h00; v0 = 8'h00; v1 = 8'h00;
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(phase, scs_pkg::ST_COPY);
    chk({outs, bus_out, grant, busy}, 0);
    @(posedge i_ref_clk) i_reset <= 1'b0;
    n = 0;
    @(negedge i_ref_clk);
    while (phase === scs_pkg::ST_COPY && n < 40) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk(n, 16);
    chk(phase, scs_pkg::ST_CLEAR);
    @(negedge i_ref_clk) chk(phase, scs_pkg::ST_CHECK);
    @(negedge i_ref_clk) chk(phase, scs_pkg::ST_COMMON);
    for (int t = 0; t < 6; t++) begin
      v1 = v0;
      v0 = (t == 5) ? 8'h05 : 8'($urandom);
      scan(v0);
      if (t > 0) chk({outs, bus_out}, {f_out(v1), f_out(v1)});
    end
    cfg.filter_val = 8'h0A;
    scan(8'h02);
    scan(8'h02);
    chk(outs, f_out(8'h05));
    scan(8'h02);
    chk(outs, f_out(8'h02));
    for (int t = 0; t < 4; t++) begin
      cfg.host_b = t[1];
      cfg.chan_count = (t == 1) ? 4'h3 : 4'(t[1] * 2);
      n = 0;
      while (busy !== 1'b0 && n < 300) @(negedge i_ref_clk) n++;
      while (busy !== 1'b1 && n < 300) @(negedge i_ref_clk) n++;
      n = 0;
      while (busy === 1'b1 && n < 300) @(negedge i_ref_clk) n++;
      if (t[1]) chk(n, (5 + cfg.chan_count) * MS);
      else chk(n, ((cfg.chan_count > 1) ? 2 * cfg.chan_count : 2) * MS);
    end
    wait_ph(scs_pkg::ST_COMMON);
    @(posedge i_ref_clk) end_addr <= 4'hF;
    wait_ph(scs_pkg::ST_HALT);
    chk(n >= WD && n <= WD + 2, 1);
    repeat (40) @(negedge i_ref_clk);
    chk({phase, wdog_err, grant}, {scs_pkg::ST_HALT, 2'b10});
    @(posedge i_ref_clk) begin
      i_err_clear <= 1'b1;
      link_up     <= 1'b0;
      end_addr    <= 4'h6;
    end
    @(posedge i_ref_clk) i_err_clear <= 1'b0;
    @(negedge i_ref_clk) chk({phase, wdog_err}, {scs_pkg::ST_COPY, 1'b0});
    wait_ph(scs_pkg::ST_HALT);
    chk({init_err, wdog_err}, 2'b10);
    @(posedge i_ref_clk) begin
      i_err_clear <= 1'b1;
      link_up     <= 1'b1;
    end
    @(posedge i_ref_clk) i_err_clear <= 1'b0;
    wait_ph(scs_pkg::ST_COMMON);
    chk({phase, init_err}, {scs_pkg::ST_COMMON, 1'b0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
